//--- verilog/sdcl_loader.v
// Configuration loader of a clock synthesizer: divisor latches, serial shifter,
// feedback and output dividers driven by an oversampled loop clock stand-in.
// Assumes all configuration pins are asynchronous to core_clk and are slower
// than a few core_clk periods per level, so edges are found after sync.
`timescale 1ns/1ps
`include "sdcl_map.vh"

// How it works
// (R1) Clear high holds dividers in reset; true outputs low, complements high.
// (R2) Clear low lets dividers run and drives both differential outputs.
// (R3) Clear never touches stored feedback, output divisor or diagnostic bits.
// (R4) Host sets serial data before shift clock rise; device samples on the rise.
// (R5) Reference select high picks crystal, low picks the alternate reference.
// (R6) Bypass select high runs the loop; low passes the reference straight through.
// (R7) Parallel strobe low passes divisor pins directly; diagnostic output low.
// (R8) Parallel strobe rise with transfer low latches pins until next fall or serial load.
// (R9) Strobe high, transfer low: shift serial data on each shift clock rise.
// (R10) Transfer strobe rise passes shift register contents to the dividers.
// (R11) Transfer strobe fall latches the transferred divisor values.
// (R12) In serial idle, parallel pin changes do not alter latched divisors.
// (R13) Transfer held high: serial data flows straight to dividers each shift rise.
// (R14) Feedback divisor is a plain unsigned 9-bit value.
// (R15) Host keeps feedback divisor within 10 to 28 at a 25 MHz reference.
// (R16) Output divisor codes 0..3 divide by 1, 2, 4, 8.
// (R17) Serial mode diagnostic: low, serial input, feedback divider, clock copy.
// (R18) Frame is 13 bits MSB first: diagnostic, output divisor, feedback divisor.
// (R19) Latches transparent while load path open; pins pass two-stage sync.
module sdcl_loader (
    input wire core_clk,
    input wire resetn,
    input wire divider_clear_input,
    input wire parallel_latch_strobe_n,
    input wire [`SDCL_FB_W-1:0] feedback_divisor_bits,
    input wire [`SDCL_OD_W-1:0] output_divisor_bits,
    input wire serial_shift_clock,
    input wire serial_data_input,
    input wire serial_transfer_strobe,
    input wire reference_source_select,
    input wire loop_bypass_select,
    input wire crystal_ref,
    input wire alternate_ref,
    output reg [1:0] true_clock_outputs,
    output reg [1:0] complement_clock_outputs,
    output reg diagnostic_output,
    output reg [`SDCL_FB_W-1:0] active_feedback_divisor,
    output reg [`SDCL_OD_W-1:0] active_output_divisor,
    output reg [`SDCL_DG_W-1:0] active_diagnostic_select,
    output reg serial_mode,
    output reg bypass_active,
    output reg reference_clock
);

    // ****************************************
    // Reset release and pin synchronisation
    // ****************************************
    reg rst_meta;
    reg rst_n;

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    localparam SW = 8 + `SDCL_FB_W + `SDCL_OD_W;
    wire [SW-1:0] pins_sync;

    sdcl_sync #(
        .W(SW)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({divider_clear_input, parallel_latch_strobe_n, serial_shift_clock, serial_data_input,
            serial_transfer_strobe, reference_source_select, loop_bypass_select, crystal_ref,
            feedback_divisor_bits, output_divisor_bits}),
        .sync_out(pins_sync)
    ); // R19

    wire clr_s = pins_sync[SW-1];
    wire pstb_n_s = pins_sync[SW-2];
    wire sclk_s = pins_sync[SW-3];
    wire sdat_s = pins_sync[SW-4];
    wire sload_s = pins_sync[SW-5];
    wire rsel_s = pins_sync[SW-6];
    wire byp_s = pins_sync[SW-7];
    wire xtal_s = pins_sync[SW-8];
    wire [`SDCL_FB_W-1:0] fb_pins_s = pins_sync[`SDCL_FB_W+`SDCL_OD_W-1:`SDCL_OD_W];
    wire [`SDCL_OD_W-1:0] od_pins_s = pins_sync[`SDCL_OD_W-1:0];

    // Alternate reference is kept separate: it is a data copy, never an edge source
    reg alt_meta;
    reg alt_s;
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alt_meta <= 1'b0;
            alt_s <= 1'b0;
        end
        else
        begin
            alt_meta <= alternate_ref;
            alt_s <= alt_meta;
        end
    end

    // ****************************************
    // Edge detection on synchronised strobes
    // ****************************************
    reg sclk_d;
    reg sload_d;
    reg pstb_n_d;

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_d <= 1'b0;
            sload_d <= 1'b0;
            pstb_n_d <= 1'b0;
        end
        else
        begin
            sclk_d <= sclk_s;
            sload_d <= sload_s;
            pstb_n_d <= pstb_n_s;
        end
    end

    wire sclk_rise = sclk_s & ~sclk_d; // R4
    wire sload_rise = sload_s & ~sload_d;
    wire pstb_rise = pstb_n_s & ~pstb_n_d;

    // ****************************************
    // Shift register and divisor latches
    // ****************************************
    reg [`SDCL_FRAME_W-1:0] shifter;
    wire [`SDCL_FRAME_W-1:0] shifted = {shifter[`SDCL_FRAME_W-2:0], sdat_s};

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            shifter <= {`SDCL_FRAME_W{1'b0}};
        else if (pstb_n_s && sclk_rise)
            shifter <= shifted; // R9 R18
    end

    // Latched values: clear input deliberately absent from this process
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active_feedback_divisor <= `SDCL_FB_RST;
            active_output_divisor <= `SDCL_OD_RST;
            active_diagnostic_select <= `SDCL_DG_RST;
        end
        else if (!pstb_n_s || (pstb_rise && !sload_s))
        begin
            // Transparent while low; the rising edge captures the last value
            active_feedback_divisor <= fb_pins_s; // R7 R8 R19 R3
            active_output_divisor <= od_pins_s;
        end
        else if (sload_s && sload_rise)
        begin
            active_feedback_divisor <= shifter[`SDCL_FR_FB_HI:`SDCL_FR_FB_LO]; // R10 R18
            active_output_divisor <= shifter[`SDCL_FR_OD_HI:`SDCL_FR_OD_LO];
            active_diagnostic_select <= shifter[`SDCL_FR_DG_HI:`SDCL_FR_DG_LO];
        end
        else if (sload_s && sclk_rise)
        begin
            active_feedback_divisor <= shifted[`SDCL_FR_FB_HI:`SDCL_FR_FB_LO]; // R13
            active_output_divisor <= shifted[`SDCL_FR_OD_HI:`SDCL_FR_OD_LO];
            active_diagnostic_select <= shifted[`SDCL_FR_DG_HI:`SDCL_FR_DG_LO];
        end
        // Otherwise hold: strobe fall freezes transferred values, pins ignored R11 R12
    end

    // ****************************************
    // Reference and dividers
    // ****************************************
    // Output divisor decode: ratio minus one as a mask of counter bits
    function [2:0] sdcl_od_mask;
        input [`SDCL_OD_W-1:0] code;
        begin
            case (code)
                2'h0: sdcl_od_mask = 3'h0;
                2'h1: sdcl_od_mask = 3'h1;
                2'h2: sdcl_od_mask = 3'h3;
                default: sdcl_od_mask = 3'h7;
            endcase
        end
    endfunction

    wire ref_sel = rsel_s ? xtal_s : alt_s; // R5

    // The analog loop is modelled by core_clk ticks; feedback counter divides by M
    reg [`SDCL_FB_W-1:0] fb_count;
    reg fb_div_out;
    reg [2:0] od_count;
    reg clk_copy;

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fb_count <= {`SDCL_FB_W{1'b0}};
            fb_div_out <= 1'b0;
            od_count <= 3'h0;
            clk_copy <= 1'b0;
        end
        else if (clr_s)
        begin
            fb_count <= {`SDCL_FB_W{1'b0}}; // R1
            fb_div_out <= 1'b0;
            od_count <= 3'h0;
            clk_copy <= 1'b0;
        end
        else
        begin
            // Unsigned compare of the plain binary divisor R14 R2
            if (fb_count + 9'h001 >= active_feedback_divisor)
            begin
                fb_count <= {`SDCL_FB_W{1'b0}};
                fb_div_out <= ~fb_div_out;
            end
            else
                fb_count <= fb_count + 9'h001;
            if (!byp_s)
                clk_copy <= ref_sel; // R6
            else if ((od_count & sdcl_od_mask(active_output_divisor)) == sdcl_od_mask(active_output_divisor))
            begin
                od_count <= 3'h0; // R16
                clk_copy <= ~clk_copy;
            end
            else
                od_count <= od_count + 3'h1;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            true_clock_outputs <= 2'h0;
            complement_clock_outputs <= 2'h3;
            diagnostic_output <= 1'b0;
            serial_mode <= 1'b0;
            bypass_active <= 1'b0;
            reference_clock <= 1'b0;
        end
        else
        begin
            serial_mode <= pstb_n_s;
            bypass_active <= ~byp_s;
            reference_clock <= ref_sel;
            if (clr_s)
            begin
                true_clock_outputs <= 2'h0; // R1
                complement_clock_outputs <= 2'h3;
            end
            else
            begin
                true_clock_outputs <= {2{clk_copy}}; // R2
                complement_clock_outputs <= {2{~clk_copy}};
            end
            if (!pstb_n_s)
                diagnostic_output <= 1'b0; // R7
            else
                case (active_diagnostic_select) // R17
                    `SDCL_DG_LOW: diagnostic_output <= 1'b0;
                    `SDCL_DG_SDATA: diagnostic_output <= sdat_s;
                    `SDCL_DG_FBDIV: diagnostic_output <= fb_div_out;
                    default: diagnostic_output <= clk_copy;
                endcase
        end
    end

endmodule // sdcl_loader

//--- verilog/sdcl_map.vh
// Constants of the synthesizer divider configuration loader.
// Assumes inclusion by bare name from the design files.
`ifndef SDCL_MAP_VH
`define SDCL_MAP_VH

`define SDCL_FB_W 9
`define SDCL_OD_W 2
`define SDCL_DG_W 2
`define SDCL_FRAME_W 13
// Frame field positions, most significant bit shifted first
`define SDCL_FR_DG_HI 12
`define SDCL_FR_DG_LO 11
`define SDCL_FR_OD_HI 10
`define SDCL_FR_OD_LO 9
`define SDCL_FR_FB_HI 8
`define SDCL_FR_FB_LO 0
// Diagnostic selector codes
`define SDCL_DG_LOW 2'h0
`define SDCL_DG_SDATA 2'h1
`define SDCL_DG_FBDIV 2'h2
`define SDCL_DG_CLKOUT 2'h3
// Reset values
`define SDCL_FB_RST 9'h000
`define SDCL_OD_RST 2'h0
`define SDCL_DG_RST 2'h0

`endif

//--- verilog/sdcl_sync.v
// Two flip-flop synchroniser for a group of asynchronous pin levels.
// Assumes an active-low asynchronous reset already released in core_clk.
`timescale 1ns/1ps

module sdcl_sync #(
    parameter W = 1
) (
    input wire core_clk,
    input wire rst_n,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);

    reg [W-1:0] stage1;

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // sdcl_sync

//--- tb/sdcl_host.sv
// Host model driving the loader's parallel and serial configuration pins.
// Assumes core_clk from the bench; pins move on falling edges only.
`timescale 1ns/1ps

module sdcl_host (
    input wire core_clk,
    output reg parallel_latch_strobe_n = 1'b0,
    output reg [8:0] feedback_divisor_bits = 9'h000,
    output reg [1:0] output_divisor_bits = 2'h0,
    output reg serial_shift_clock = 1'b0,
    output reg serial_data_input = 1'b0,
    output reg serial_transfer_strobe = 1'b0
);
    // ****
    // Pin sequences
    // ****
    // Four cycles per level outlast the two-stage pin sync
    task hold;
        repeat (4) @(negedge core_clk);
    endtask
    task par(input [8:0] m, input [1:0] n, input lo, input up);
        parallel_latch_strobe_n = lo;
        feedback_divisor_bits = m;
        output_divisor_bits = n;
        hold;
        parallel_latch_strobe_n = up;
        hold;
    endtask
    task ser(input [12:0] f);
        integer i;
        parallel_latch_strobe_n = 1'b1;
        for (i = 12; i >= 0; i = i - 1)
        begin
            serial_data_input = f[i];
            hold;
            serial_shift_clock = 1'b1;
            hold;
            serial_shift_clock = 1'b0;
        end
        hold;
        // Idle data is the inverse of the last bit, never a stale copy
        serial_data_input = ~serial_data_input;
    endtask
    task xfer(input v);
        serial_transfer_strobe = v;
        repeat (8) @(negedge core_clk);
    endtask
endmodule // sdcl_host

//--- tb/sdcl_loader_asserts.sv
// Checker of the loader's pin relations, bound to sdcl_loader.
// Assumes pin levels are held for several core_clk cycles.
`timescale 1ns/1ps

module sdcl_chk (
    input wire core_clk,
    input wire resetn,
    input wire divider_clear_input,
    input wire parallel_latch_strobe_n,
    input wire [8:0] feedback_divisor_bits,
    input wire serial_data_input,
    input wire serial_transfer_strobe,
    input wire loop_bypass_select,
    input wire [1:0] true_clock_outputs,
    input wire [1:0] complement_clock_outputs,
    input wire diagnostic_output,
    input wire [8:0] active_feedback_divisor,
    input wire [1:0] active_diagnostic_select,
    input wire bypass_active
);
    // ****
    // Properties: five- and six-cycle windows cover the three-cycle pin latency
    // ****
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    property p_clr; divider_clear_input [*5] |-> true_clock_outputs == 2'h0 && complement_clock_outputs == 2'h3; endproperty
    a_clr: assert property (p_clr) else $error("outputs not parked");
    property p_run; !divider_clear_input [*6] |-> complement_clock_outputs == ~true_clock_outputs; endproperty
    a_run: assert property (p_run) else $error("pair not inverse");
    // Slowest output ratio toggles every eight cycles, one more for the output register
    property p_tick;
        (!divider_clear_input && loop_bypass_select) [*6] |-> ##[1:9] $changed(true_clock_outputs);
    endproperty
    a_tick: assert property (p_tick) else $error("outputs not toggling");
    property p_keep; $rose(divider_clear_input) && parallel_latch_strobe_n |=> $stable(active_feedback_divisor) [*8]; endproperty
    a_keep: assert property (p_keep) else $error("clear moved divisor");
    property p_byp; $stable(loop_bypass_select) [*6] |-> bypass_active == !loop_bypass_select; endproperty
    a_byp: assert property (p_byp) else $error("bypass wrong");
    property p_plow; !parallel_latch_strobe_n [*5] |-> !diagnostic_output; endproperty
    a_plow: assert property (p_plow) else $error("diag not low");
    property p_pass;
        (!parallel_latch_strobe_n && $stable(feedback_divisor_bits)) [*6] |-> active_feedback_divisor == feedback_divisor_bits;
    endproperty
    a_pass: assert property (p_pass) else $error("pins not passed");
    property p_hold; (parallel_latch_strobe_n && !serial_transfer_strobe) [*6] |=> $stable(active_feedback_divisor); endproperty
    a_hold: assert property (p_hold) else $error("latched divisor moved");
    property p_sd;
        (parallel_latch_strobe_n && active_diagnostic_select == 2'h1 && $stable(serial_data_input)) [*6]
            |-> diagnostic_output == serial_data_input;
    endproperty
    a_sd: assert property (p_sd) else $error("diag not serial input");
    c_clr: cover property (divider_clear_input [*5]);
    c_xfer: cover property ($fell(serial_transfer_strobe));
    c_sd: cover property (parallel_latch_strobe_n && active_diagnostic_select == 2'h1);
endmodule // sdcl_chk

bind sdcl_loader sdcl_chk u_sdcl_chk (.core_clk, .resetn, .divider_clear_input, .parallel_latch_strobe_n,
    .feedback_divisor_bits, .serial_data_input, .serial_transfer_strobe, .loop_bypass_select, .true_clock_outputs,
    .complement_clock_outputs, .diagnostic_output, .active_feedback_divisor, .active_diagnostic_select, .bypass_active);

//--- tb/testbench.sv
// Bench of the loader: parallel table, serial frames, clear, reference, bypass.
// Assumes sdcl_host drives the configuration pins and the checker is bound.
`timescale 1ns/1ps

module testbench;
    reg core_clk = 1'b0;
    reg resetn;
    reg divider_clear_input;
    reg reference_source_select;
    reg loop_bypass_select;
    reg crystal_ref;
    reg alternate_ref;
    reg psel = 1'b0;
    int err_total = 0;
    int n_checks = 0;
    int n;
    wire parallel_latch_strobe_n, serial_shift_clock, serial_data_input, serial_transfer_strobe;
    wire diagnostic_output, serial_mode, bypass_active, reference_clock;
    wire [8:0] feedback_divisor_bits, active_feedback_divisor;
    wire [1:0] output_divisor_bits, true_clock_outputs, complement_clock_outputs;
    wire [1:0] active_output_divisor, active_diagnostic_select;
    wire probe = psel ? diagnostic_output : true_clock_outputs[0];
    // Feedback divisor, output code, expected half period of the output clock
    logic [14:0] rows [4] = '{{9'h00a, 2'h0, 4'h1}, {9'h01c, 2'h1, 4'h2}, {9'h01b, 2'h2, 4'h4}, {9'h00d, 2'h3, 4'h8}};
    sdcl_host u_sdcl_host (.core_clk, .parallel_latch_strobe_n, .feedback_divisor_bits, .output_divisor_bits,
        .serial_shift_clock, .serial_data_input, .serial_transfer_strobe);
    sdcl_loader u_sdcl_loader (.core_clk, .resetn, .divider_clear_input, .parallel_latch_strobe_n,
        .feedback_divisor_bits, .output_divisor_bits, .serial_shift_clock, .serial_data_input,
        .serial_transfer_strobe, .reference_source_select, .loop_bypass_select, .crystal_ref, .alternate_ref,
        .true_clock_outputs, .complement_clock_outputs, .diagnostic_output, .active_feedback_divisor,
        .active_output_divisor, .active_diagnostic_select, .serial_mode, .bypass_active, .reference_clock);
    initial
        forever #5 core_clk = ~core_clk;
    // ****
    // Checking tasks
    // ****
    task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task close_out;
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task settle;
        repeat (8) @(negedge core_clk);
    endtask
    // Second of two level changes of probe gives one whole half period
    task per(output int k);
        logic p;
        repeat (2)
        begin
            p = probe;
            k = 0;
            while (probe === p && k < 40)
            begin
                @(negedge core_clk);
                k++;
            end
        end
        if (k >= 40)
        begin
            cmp("timeout", 16'h0000, 16'h0001);
            close_out;
        end
    endtask
    // ****
    // Main sequence
    // ****
    initial
    begin
        resetn = 1'b0;
        divider_clear_input = 1'b0;
        reference_source_select = 1'b1;
        loop_bypass_select = 1'b1;
        crystal_ref = 1'b0;
        alternate_ref = 1'b0;
        repeat (16) @(negedge core_clk);
        resetn = 1'b1;
        settle;
        foreach (rows[i])
        begin
            u_sdcl_host.par(rows[i][14:6], rows[i][5:4], 1'b0, 1'b0);
            cmp("afb", rows[i][14:6], active_feedback_divisor);
            cmp("aod", rows[i][5:4], active_output_divisor);
            per(n);
            cmp("out_half", rows[i][3:0], 16'(n));
        end
        u_sdcl_host.par(9'h014, 2'h1, 1'b0, 1'b1);
        u_sdcl_host.par(9'h016, 2'h3, 1'b1, 1'b1);
        cmp("afb_latch", 9'h014, active_feedback_divisor);
        u_sdcl_host.ser({2'h2, 2'h1, 9'h00c});
        cmp("afb_shift", 9'h014, active_feedback_divisor);
        u_sdcl_host.xfer(1'b1);
        cmp("afb_xfer", 9'h00c, active_feedback_divisor);
        cmp("ads_xfer", 2'h2, active_diagnostic_select);
        u_sdcl_host.xfer(1'b0);
        psel = 1'b1;
        per(n);
        cmp("fb_half", 16'h000c, 16'(n));
        u_sdcl_host.ser({2'h3, 2'h3, 9'h011});
        cmp("afb_held", 9'h00c, active_feedback_divisor);
        u_sdcl_host.xfer(1'b1);
        u_sdcl_host.xfer(1'b0);
        cmp("aod_xfer", 2'h3, active_output_divisor);
        per(n);
        cmp("copy_half", 16'h0008, 16'(n));
        u_sdcl_host.xfer(1'b1);
        u_sdcl_host.ser({2'h0, 2'h2, 9'h019});
        cmp("afb_direct", 9'h019, active_feedback_divisor);
        cmp("diag_low", 1'b0, diagnostic_output);
        u_sdcl_host.ser({2'h1, 2'h0, 9'h00a});
        u_sdcl_host.xfer(1'b0);
        // Idle data is the inverse of the last frame bit, which is zero
        cmp("diag_sd", 16'h0001, diagnostic_output);
        divider_clear_input = 1'b1;
        settle;
        cmp("tco_clr", 2'h0, true_clock_outputs);
        cmp("cco_clr", 2'h3, complement_clock_outputs);
        cmp("afb_clr", 9'h00a, active_feedback_divisor);
        divider_clear_input = 1'b0;
        settle;
        cmp("cco_run", 16'h0003, true_clock_outputs ^ complement_clock_outputs);
        psel = 1'b0;
        per(n);
        cmp("run_half", 16'h0001, 16'(n));
        crystal_ref = 1'b1;
        settle;
        cmp("ref_xtal", 1'b1, reference_clock);
        reference_source_select = 1'b0;
        crystal_ref = 1'b0;
        alternate_ref = 1'b1;
        settle;
        cmp("ref_alt", 16'h0001, reference_clock);
        loop_bypass_select = 1'b0;
        settle;
        cmp("bypass", 1'b1, bypass_active);
        cmp("tco_byp", 16'h0003, true_clock_outputs);
        cmp("smode", 1'b1, serial_mode);
        u_sdcl_host.par(9'h01c, 2'h0, 1'b0, 1'b0);
        cmp("diag_par", 1'b0, diagnostic_output);
        cmp("smode_par", 16'h0000, serial_mode);
        // Mid-run reset: outputs park, then the open parallel path reloads the pins
        resetn = 1'b0;
        settle;
        cmp("tco_rst", 16'h0000, true_clock_outputs);
        cmp("cco_rst", 16'h0003, complement_clock_outputs);
        resetn = 1'b1;
        settle;
        cmp("afb_rst", 16'h001c, active_feedback_divisor);
        cmp("aod_rst", 16'h0000, active_output_divisor);
        close_out;
    end
endmodule // testbench
